// ### rtl/mhf_map.svh
// register offsets, field positions and sizes of the header frame filter
`ifndef MHF_MAP_SVH
`define MHF_MAP_SVH
// eight filters on this port
`define MHF_NFILT 8
`define MHF_FIFO_DEPTH 8
`define MHF_AW 10
// per-filter window: byte address = filter index * 0x40 + offset
`define MHF_OFF_CTRL 6'h00
`define MHF_OFF_DVAL_LO 6'h04
`define MHF_OFF_DVAL_HI 6'h08
`define MHF_OFF_DMSK_LO 6'h0c
`define MHF_OFF_DMSK_HI 6'h10
`define MHF_OFF_SVAL_LO 6'h14
`define MHF_OFF_SVAL_HI 6'h18
`define MHF_OFF_SMSK_LO 6'h1c
`define MHF_OFF_SMSK_HI 6'h20
`define MHF_OFF_ETYPE 6'h24
// global registers
`define MHF_ADDR_STAT 10'h200
`define MHF_ADDR_FRAMES 10'h204
`define MHF_ADDR_HITS 10'h208
// control word bits
`define MHF_CTRL_FMODE 0
`define MHF_CTRL_DMODE 1
`define MHF_CTRL_SMODE 2
`define MHF_CTRL_EMODE 3
// ethertype word: value low half, mask high half
`define MHF_ETYPE_MSK_POS 16
// status word bits
`define MHF_STAT_HIT 0
`define MHF_STAT_IDX_LO 1
`define MHF_STAT_PEND 4
`endif

// ### rtl/mhf_pkg.sv
// types of the header frame filter
package mhf_pkg;
  // filter mode: block matches nothing, custom uses field rules
  typedef enum logic {MHF_FM_BLOCK, MHF_FM_CUSTOM} mhf_fmode_t;
  // per-field match mode
  typedef enum logic {MHF_MM_IGNORE, MHF_MM_EQUAL} mhf_mmode_t;
  // header bytes 0-5, 6-11, 12-13
  typedef struct packed {
    logic [47:0] dst;
    logic [47:0] src;
    logic [15:0] etype;
  } mhf_hdr_t;
  // one filter's configuration
  typedef struct packed {
    mhf_fmode_t fmode;
    mhf_mmode_t dmode;
    mhf_mmode_t smode;
    mhf_mmode_t emode;
    logic [47:0] dval;
    logic [47:0] dmsk;
    logic [47:0] sval;
    logic [47:0] smsk;
    logic [15:0] eval;
    logic [15:0] emsk;
  } mhf_fcfg_t;
  // verdict for one header
  typedef struct packed {
    logic hit;
    logic [2:0] idx;
  } mhf_res_t;
endpackage

// ### rtl/mhf_fifo.sv
// parameterised flip-flop fifo with valid/ready on both sides
`timescale 1ns/1ps
module mhf_fifo #(
  parameter int W = 8,
  parameter int D = 8
)
(
  // clock and reset
  input wire logic mclk_in,
  input wire logic rst_n_in,
  // fill side
  input wire logic in_valid_in,
  input wire logic [W-1:0] in_data_in,
  output logic in_ready_out,
  // drain side
  output logic out_valid_out,
  output logic [W-1:0] out_data_out,
  input wire logic out_ready_in
);
  localparam int PW = $clog2(D);
  localparam int CW = $clog2(D + 1);
  logic [W-1:0] mem_q [D];
  logic [PW-1:0] wp_q, rp_q;
  logic [CW-1:0] cnt_q, cnt_d;
  logic in_rdy_q, out_vld_q;
  logic push, pop;

  // handshakes; ready and valid come from flops so full/empty are honest
  assign push = in_valid_in && in_rdy_q;
  assign pop = out_valid_out && out_ready_in;
  assign cnt_d = cnt_q + CW'(push) - CW'(pop);
  assign in_ready_out = in_rdy_q;
  assign out_valid_out = out_vld_q;
  assign out_data_out = mem_q[rp_q];

  // storage needs no reset, only the pointers, fill level and flags do
  always_ff @(posedge mclk_in)
  begin
    if (push)
      mem_q[wp_q] <= in_data_in;
  end

  // pointers, fill level and flags
  always_ff @(posedge mclk_in)
  begin
    if (!rst_n_in)
    begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
      in_rdy_q <= 1'b1;
      out_vld_q <= 1'b0;
    end
    else
    begin
      if (push)
        wp_q <= (wp_q == PW'(D - 1)) ? '0 : wp_q + PW'(1);
      if (pop)
        rp_q <= (rp_q == PW'(D - 1)) ? '0 : rp_q + PW'(1);
      cnt_q <= cnt_d;
      in_rdy_q <= (cnt_d != CW'(D));
      out_vld_q <= (cnt_d != '0);
    end
  end
endmodule

// ### rtl/mhf_filter.sv
// header frame filter: eight prioritised mac/ethertype filters behind a fifo
//
// Chosen here: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
`include "mhf_map.svh"
module mhf_filter
(
  // clock and reset
  input wire logic mclk_in,
  input wire logic rst_n_in,
  // register port
  input wire logic [`MHF_AW-1:0] addr_in,
  input wire logic [31:0] wr_data_in,
  input wire logic wr_en_in,
  input wire logic rd_en_in,
  output logic [31:0] rd_data_out,
  // header stream in
  input wire logic hdr_valid_in,
  input wire mhf_pkg::mhf_hdr_t hdr_in,
  output logic hdr_ready_out,
  // verdict stream out
  output logic res_valid_out,
  output mhf_pkg::mhf_res_t res_out,
  input wire logic res_ready_in
);
  import mhf_pkg::*;

  localparam int NF = `MHF_NFILT;

  // masked equality, used for all three fields
  function automatic logic mhf_meq(input logic [47:0] f, input logic [47:0] v, input logic [47:0] m);
    return (f & m) == (v & m);
  endfunction

  // lowest index has highest precedence
  function automatic logic [2:0] mhf_first(input logic [NF-1:0] v);
    logic [2:0] r;
    r = 3'h0;
    for (int k = NF - 1; k >= 0; k--)
      if (v[k])
        r = 3'(k);
    return r;
  endfunction

  // read view of one filter's registers
  function automatic logic [31:0] mhf_cfg_word(input mhf_fcfg_t c, input logic [5:0] off);
    logic [31:0] w;
    w = 32'h0;
    case (off)
      `MHF_OFF_CTRL:
      begin
        w[`MHF_CTRL_FMODE] = c.fmode;
        w[`MHF_CTRL_DMODE] = c.dmode;
        w[`MHF_CTRL_SMODE] = c.smode;
        w[`MHF_CTRL_EMODE] = c.emode;
      end
      `MHF_OFF_DVAL_LO: w = c.dval[31:0];
      `MHF_OFF_DVAL_HI: w = {16'h0, c.dval[47:32]};
      `MHF_OFF_DMSK_LO: w = c.dmsk[31:0];
      `MHF_OFF_DMSK_HI: w = {16'h0, c.dmsk[47:32]};
      `MHF_OFF_SVAL_LO: w = c.sval[31:0];
      `MHF_OFF_SVAL_HI: w = {16'h0, c.sval[47:32]};
      `MHF_OFF_SMSK_LO: w = c.smsk[31:0];
      `MHF_OFF_SMSK_HI: w = {16'h0, c.smsk[47:32]};
      `MHF_OFF_ETYPE: w = {c.emsk, c.eval};
      default: w = 32'h0;
    endcase
    return w;
  endfunction

  mhf_fcfg_t cfg_q [NF];
  mhf_hdr_t fhdr;
  logic fvalid, take;
  logic [NF-1:0] hit_vec, blk_vec, noeq_vec;
  logic [NF-1:0] d_ok, s_ok, e_ok;
  logic any_hit;
  logic [2:0] first_idx;
  logic res_valid_q;
  mhf_res_t res_q;
  logic last_hit_q;
  logic [2:0] last_idx_q;
  logic [31:0] frames_q, hits_q;
  logic [31:0] rd_data_q, rd_mux;
  logic in_filt;
  logic [2:0] fsel;
  logic [5:0] roff;

  // headers queue ahead of the matcher; a stalled verdict fills it
  mhf_fifo #(
    .W($bits(mhf_hdr_t)),
    .D(`MHF_FIFO_DEPTH)
  ) u_fifo (
    .mclk_in(mclk_in),
    .rst_n_in(rst_n_in),
    .in_valid_in(hdr_valid_in),
    .in_data_in(hdr_in),
    .in_ready_out(hdr_ready_out),
    .out_valid_out(fvalid),
    .out_data_out(fhdr),
    .out_ready_in(take)
  );

  // register address split
  assign in_filt = !addr_in[9];
  assign fsel = addr_in[8:6];
  assign roff = addr_in[5:0];

  // per-filter configuration and matching
  genvar gi;
  generate
    for (gi = 0; gi < NF; gi++)
    begin : g_flt
      logic wsel;
      assign wsel = wr_en_in && in_filt && (fsel == 3'(gi));

      // software writes the filter words
      always_ff @(posedge mclk_in)
      begin
        if (!rst_n_in)
          cfg_q[gi] <= '0;
        else if (wsel)
        begin
          case (roff)
            `MHF_OFF_CTRL:
            begin
              cfg_q[gi].fmode <= mhf_fmode_t'(wr_data_in[`MHF_CTRL_FMODE]);
              cfg_q[gi].dmode <= mhf_mmode_t'(wr_data_in[`MHF_CTRL_DMODE]);
              cfg_q[gi].smode <= mhf_mmode_t'(wr_data_in[`MHF_CTRL_SMODE]);
              cfg_q[gi].emode <= mhf_mmode_t'(wr_data_in[`MHF_CTRL_EMODE]);
            end
            `MHF_OFF_DVAL_LO: cfg_q[gi].dval[31:0] <= wr_data_in;
            `MHF_OFF_DVAL_HI: cfg_q[gi].dval[47:32] <= wr_data_in[15:0];
            `MHF_OFF_DMSK_LO: cfg_q[gi].dmsk[31:0] <= wr_data_in;
            `MHF_OFF_DMSK_HI: cfg_q[gi].dmsk[47:32] <= wr_data_in[15:0];
            `MHF_OFF_SVAL_LO: cfg_q[gi].sval[31:0] <= wr_data_in;
            `MHF_OFF_SVAL_HI: cfg_q[gi].sval[47:32] <= wr_data_in[15:0];
            `MHF_OFF_SMSK_LO: cfg_q[gi].smsk[31:0] <= wr_data_in;
            `MHF_OFF_SMSK_HI: cfg_q[gi].smsk[47:32] <= wr_data_in[15:0];
            `MHF_OFF_ETYPE:
            begin
              cfg_q[gi].eval <= wr_data_in[15:0];
              cfg_q[gi].emsk <= wr_data_in[`MHF_ETYPE_MSK_POS +: 16];
            end
            default:
            begin
            end
          endcase
        end
      end

      // field comparisons on the queued header
      assign d_ok[gi] = mhf_meq(fhdr.dst, cfg_q[gi].dval, cfg_q[gi].dmsk);
      assign s_ok[gi] = mhf_meq(fhdr.src, cfg_q[gi].sval, cfg_q[gi].smsk);
      assign e_ok[gi] = mhf_meq({32'h0, fhdr.etype}, {32'h0, cfg_q[gi].eval},
                                {32'h0, cfg_q[gi].emsk});

      // ignore fields never select; all equal fields must agree
      assign blk_vec[gi] = (cfg_q[gi].fmode == MHF_FM_BLOCK);
      assign noeq_vec[gi] = (cfg_q[gi].dmode == MHF_MM_IGNORE) && (cfg_q[gi].smode == MHF_MM_IGNORE)
                            && (cfg_q[gi].emode == MHF_MM_IGNORE);
      assign hit_vec[gi] = !blk_vec[gi] && !noeq_vec[gi]
                           && (cfg_q[gi].dmode == MHF_MM_IGNORE || d_ok[gi])
                           && (cfg_q[gi].smode == MHF_MM_IGNORE || s_ok[gi])
                           && (cfg_q[gi].emode == MHF_MM_IGNORE || e_ok[gi]);

      // a source equal-mode hit needs the masked source to agree
      src_match_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        fvalid && hit_vec[gi] && cfg_q[gi].smode == MHF_MM_EQUAL
        |-> ((fhdr.src & cfg_q[gi].smsk) == (cfg_q[gi].sval & cfg_q[gi].smsk)))
        else $error("source mismatch yet filter hit");
      // same for the destination
      dst_match_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        fvalid && hit_vec[gi] && cfg_q[gi].dmode == MHF_MM_EQUAL
        |-> ((fhdr.dst & cfg_q[gi].dmsk) == (cfg_q[gi].dval & cfg_q[gi].dmsk)))
        else $error("destination mismatch yet filter hit");
      // same for the ethertype
      etype_match_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        fvalid && hit_vec[gi] && cfg_q[gi].emode == MHF_MM_EQUAL
        |-> ((fhdr.etype & cfg_q[gi].emsk) == (cfg_q[gi].eval & cfg_q[gi].emsk)))
        else $error("ethertype mismatch yet filter hit");

      // the converse: a custom filter with at least one equal field, all of them agreeing, must hit
      equal_pass_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        fvalid && cfg_q[gi].fmode == MHF_FM_CUSTOM && (cfg_q[gi].dmode | cfg_q[gi].smode | cfg_q[gi].emode)
        && (cfg_q[gi].dmode == MHF_MM_IGNORE || (fhdr.dst & cfg_q[gi].dmsk) == (cfg_q[gi].dval & cfg_q[gi].dmsk))
        && (cfg_q[gi].smode == MHF_MM_IGNORE || (fhdr.src & cfg_q[gi].smsk) == (cfg_q[gi].sval & cfg_q[gi].smsk))
        && (cfg_q[gi].emode == MHF_MM_IGNORE || (fhdr.etype & cfg_q[gi].emsk) == (cfg_q[gi].eval & cfg_q[gi].emsk))
        |-> hit_vec[gi])
        else $error("agreeing header missed by filter");
    end
  endgenerate

  // one verdict per header; single winner by precedence
  assign any_hit = |hit_vec;
  assign first_idx = mhf_first(hit_vec);
  assign take = fvalid && (!res_valid_q || res_ready_in);

  // verdict register holds until the receiver takes it
  always_ff @(posedge mclk_in)
  begin
    if (!rst_n_in)
    begin
      res_valid_q <= 1'b0;
      res_q <= '0;
    end
    else if (take)
    begin
      res_valid_q <= 1'b1;
      res_q.hit <= any_hit;
      res_q.idx <= any_hit ? first_idx : 3'h0;
    end
    else if (res_ready_in)
      res_valid_q <= 1'b0;
  end

  // status: last verdict and frame counters
  always_ff @(posedge mclk_in)
  begin
    if (!rst_n_in)
    begin
      last_hit_q <= 1'b0;
      last_idx_q <= 3'h0;
      frames_q <= 32'h0;
      hits_q <= 32'h0;
    end
    else if (take)
    begin
      last_hit_q <= any_hit;
      last_idx_q <= first_idx;
      frames_q <= frames_q + 32'h1;
      hits_q <= hits_q + {31'h0, any_hit};
    end
  end

  // read mux; unmapped words read zero
  assign rd_mux = in_filt ? mhf_cfg_word(cfg_q[fsel], roff) :
                  (addr_in == `MHF_ADDR_STAT) ? {27'h0, fvalid, last_idx_q, last_hit_q} :
                  (addr_in == `MHF_ADDR_FRAMES) ? frames_q :
                  (addr_in == `MHF_ADDR_HITS) ? hits_q : 32'h0;

  // read data stand only in the cycle after the strobe
  always_ff @(posedge mclk_in)
  begin
    if (!rst_n_in)
      rd_data_q <= 32'h0;
    else
      rd_data_q <= rd_en_in ? rd_mux : 32'h0;
  end

  assign rd_data_out = rd_data_q;
  assign res_valid_out = res_valid_q;
  assign res_out = res_q;

  // no blocked filter ever hits
  block_no_hit_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    fvalid |-> (hit_vec & blk_vec) == '0)
    else $error("blocked filter produced a hit");

  // a filter with every field ignored selects nothing
  ignore_none_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    fvalid |-> (hit_vec & noeq_vec) == '0)
    else $error("all-ignore filter produced a hit");

  // verdict hit bit follows the header that was taken
  verdict_hit_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    take |=> res_valid_out && res_out.hit == $past(any_hit))
    else $error("verdict hit does not match filters");

  // winner is a hitting filter with no hitting filter before it
  winner_prio_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    take && any_hit |=> (($past(hit_vec) >> res_out.idx) & 8'h01) == 8'h01
      && (($past(hit_vec) & ((8'h01 << res_out.idx) - 8'h01)) == 8'h00))
    else $error("verdict index is not the top-precedence hit");

  // a stalled verdict does not change
  verdict_hold_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    res_valid_out && !res_ready_in |=> res_valid_out && $stable(res_out))
    else $error("verdict changed while stalled");

  // the winner is checked against the live mode bits, not the hit vector
  block_winner_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    take && any_hit |-> cfg_q[first_idx].fmode == MHF_FM_CUSTOM)
    else $error("verdict points at a blocked filter");

  // a missed header reports index zero
  miss_idx_zero_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    take && !any_hit |=> !res_out.hit && res_out.idx == 3'h0)
    else $error("missed header reports a filter index");
endmodule

// ### sim/mhf_rx_model.sv
// receive path model that presents one header at a time on valid/ready
`timescale 1ns/1ps
module mhf_rx_model
(
  // clock and reset
  input wire logic mclk_in,
  input wire logic rst_n_in,
  // bench side
  input wire logic go_in,
  input wire mhf_pkg::mhf_hdr_t pend_in,
  output logic busy_out,
  // header stream
  output logic hdr_valid_out,
  output mhf_pkg::mhf_hdr_t hdr_out,
  input wire logic hdr_ready_in
);
  import mhf_pkg::*;
  assign busy_out = hdr_valid_out;
  // header held until taken; afterwards the bus shows the inverse, never stale data
  always_ff @(posedge mclk_in)
  begin
    if (!rst_n_in)
    begin
      hdr_valid_out <= 1'b0;
      hdr_out <= '0;
    end
    else if (hdr_valid_out && hdr_ready_in)
    begin
      hdr_valid_out <= 1'b0;
      hdr_out <= ~hdr_out;
    end
    else if (go_in && !hdr_valid_out)
    begin
      hdr_valid_out <= 1'b1;
      hdr_out <= pend_in;
    end
  end
endmodule

// ### sim/mhf_filter_tb.sv
// self-checking bench of the header frame filter
`timescale 1ns/1ps
`include "mhf_map.svh"
module mhf_filter_tb;
  import mhf_pkg::*;
  typedef struct packed {mhf_hdr_t h; mhf_res_t r;} mhf_row_t;
  logic mclk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [`MHF_AW-1:0] addr_in = '0;
  logic [31:0] wr_data_in = '0;
  logic wr_en_in = 1'b0;
  logic rd_en_in = 1'b0;
  logic [31:0] rd_data_out;
  logic hdr_valid_in;
  mhf_hdr_t hdr_in;
  logic hdr_ready_out;
  logic res_valid_out;
  mhf_res_t res_out;
  logic res_ready_in = 1'b0;
  logic go = 1'b0;
  mhf_hdr_t pend = '0;
  logic busy;
  int errors = 0;
  int cmp_count = 0;
  int n;
  mhf_row_t rows [9];
  mhf_filter dut (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .addr_in(addr_in), .wr_data_in(wr_data_in),
    .wr_en_in(wr_en_in), .rd_en_in(rd_en_in), .rd_data_out(rd_data_out), .hdr_valid_in(hdr_valid_in),
    .hdr_in(hdr_in), .hdr_ready_out(hdr_ready_out), .res_valid_out(res_valid_out), .res_out(res_out),
    .res_ready_in(res_ready_in));
  mhf_rx_model rx (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .go_in(go), .pend_in(pend), .busy_out(busy),
    .hdr_valid_out(hdr_valid_in), .hdr_out(hdr_in), .hdr_ready_in(hdr_ready_out));
  // 125 mhz clock
  initial
  begin
    forever #4 mclk_in = ~mclk_in;
  end
  task close_out();
    if (errors == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task chk_res(input mhf_res_t e);
    cmp_count++;
    if (res_valid_out !== 1'b1 || res_out !== e)
    begin
      errors++;
      $display("[ERR] verdict expected %h seen %h valid %b", e, res_out, res_valid_out);
    end
  endtask
  // register port: one-cycle strobes, read data in the following cycle only
  task wr(input logic [9:0] a, input logic [31:0] d);
    @(posedge mclk_in);
    addr_in <= a;
    wr_data_in <= d;
    wr_en_in <= 1'b1;
    @(posedge mclk_in);
    wr_en_in <= 1'b0;
  endtask
  task rd(input logic [9:0] a, input logic [31:0] e);
    @(posedge mclk_in);
    addr_in <= a;
    rd_en_in <= 1'b1;
    @(posedge mclk_in);
    rd_en_in <= 1'b0;
    #1;
    chk_word("rd_data", e, rd_data_out);
  endtask
  task cfg(input logic [2:0] f, input logic [31:0] c, input logic [47:0] dv, dm, sv, sm, input logic [31:0] ew);
    wr({1'b0, f, `MHF_OFF_CTRL}, c);
    wr({1'b0, f, `MHF_OFF_DVAL_LO}, dv[31:0]);
    wr({1'b0, f, `MHF_OFF_DVAL_HI}, {16'h0, dv[47:32]});
    wr({1'b0, f, `MHF_OFF_DMSK_LO}, dm[31:0]);
    wr({1'b0, f, `MHF_OFF_DMSK_HI}, {16'h0, dm[47:32]});
    wr({1'b0, f, `MHF_OFF_SVAL_LO}, sv[31:0]);
    wr({1'b0, f, `MHF_OFF_SVAL_HI}, {16'h0, sv[47:32]});
    wr({1'b0, f, `MHF_OFF_SMSK_LO}, sm[31:0]);
    wr({1'b0, f, `MHF_OFF_SMSK_HI}, {16'h0, sm[47:32]});
    wr({1'b0, f, `MHF_OFF_ETYPE}, ew);
  endtask
  // hand a header to the model and wait, bounded, until the filter takes it
  task send(input mhf_hdr_t h);
    int k;
    k = 0;
    @(posedge mclk_in);
    go <= 1'b1;
    pend <= h;
    @(posedge mclk_in);
    go <= 1'b0;
    #1;
    while (busy === 1'b1 && k < 40)
    begin
      @(posedge mclk_in);
      #1;
      k++;
    end
  endtask
  // verdict sink stalls until the verdict is checked, then accepts it
  task get(input mhf_res_t e);
    int k;
    k = 0;
    while (res_valid_out !== 1'b1 && k < 40)
    begin
      @(posedge mclk_in);
      #1;
      k++;
    end
    chk_res(e);
    @(posedge mclk_in);
    res_ready_in <= 1'b1;
    @(posedge mclk_in);
    res_ready_in <= 1'b0;
    #1;
  endtask
  // hang guard, far beyond the expected run of a few hundred cycles
  initial
  begin
    #100000;
    errors++;
    close_out();
  end
  initial
  begin
    rows = '{{48'h001122334455, 48'h0, 16'h0, 1'b1, 3'h2}, {48'h0, 48'haabbccddee5a, 16'h0, 1'b1, 3'h5},
      {48'h0, 48'haabbccddef77, 16'h0, 1'b0, 3'h0}, {48'h0, 48'h0, 16'h88f7, 1'b1, 3'h7},
      {48'h0, 48'h0, 16'h88f6, 1'b0, 3'h0}, {48'h060000000000, 48'h0, 16'h0800, 1'b1, 3'h4},
      {48'h060000000000, 48'h0, 16'h0801, 1'b0, 3'h0}, {48'h001122334454, 48'h0, 16'h0, 1'b0, 3'h0},
      {48'h001122334455, 48'haabbccddee00, 16'h88f7, 1'b1, 3'h2}};
    repeat (2) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    rd({4'h2, `MHF_OFF_CTRL}, 32'h0);
    // full masks select one value; block filter 1 would match row 0 if enabled
    cfg(3'h1, 32'h2, 48'h001122334455, '1, 48'h0, 48'h0, 32'h0);
    cfg(3'h2, 32'h3, 48'h001122334455, '1, 48'h0, 48'h0, 32'h0);
    cfg(3'h4, 32'hb, 48'h060000000000, '1, 48'h0, 48'h0, 32'hffff0800);
    cfg(3'h5, 32'h5, 48'h0, 48'h0, 48'haabbccddee77, 48'hffffffffff00, 32'h0);
    cfg(3'h6, 32'h1, 48'hffffffffffff, '1, 48'h0, 48'h0, 32'h0);
    cfg(3'h7, 32'h9, 48'h0, 48'h0, 48'h0, 48'h0, 32'hffff88f7);
    rd({4'h2, `MHF_OFF_DVAL_HI}, 32'h0011);
    rd({4'h7, `MHF_OFF_ETYPE}, 32'hffff88f7);
    for (int i = 0; i < 9; i++)
    begin
      send(rows[i].h);
      get(rows[i].r);
    end
    rd(`MHF_ADDR_STAT, 32'h5);
    wr(`MHF_ADDR_FRAMES, 32'hffff);
    rd(`MHF_ADDR_FRAMES, 32'h9);
    rd(`MHF_ADDR_HITS, 32'h5);
    rd(10'h300, 32'h0);
    // fill the fifo with the sink stalled, then drain and check the order
    n = 0;
    for (int i = 0; i < 12; i++)
    begin
      if (hdr_ready_out !== 1'b1)
        break;
      send(rows[(i % 2) * 3].h);
      n++;
    end
    // eight queued words plus the one verdict held at the stalled sink
    chk_word("fill_count", 32'h9, n);
    chk_word("hdr_ready", 32'h0, {31'h0, hdr_ready_out});
    for (int i = 0; i < n; i++)
      get(rows[(i % 2) * 3].r);
    chk_word("hdr_ready", 32'h1, {31'h0, hdr_ready_out});
    // second reset clears configuration: every filter back to block
    @(posedge mclk_in);
    rst_n_in <= 1'b0;
    repeat (2) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    #1;
    chk_word("res_valid", 32'h0, {31'h0, res_valid_out});
    chk_word("hdr_ready", 32'h1, {31'h0, hdr_ready_out});
    rd({4'h2, `MHF_OFF_CTRL}, 32'h0);
    send(rows[0].h);
    get('0);
    close_out();
  end
endmodule
